// ### bench/far_side_model.sv
/*
 Far-side model: patched outside clock source.
 Assumes clock_i is the 100 MHz core clock.
*/
module far_side_model (
	input wire logic clock_i,
	input wire logic run_i,
	input wire logic [7:0] half_i,
	output logic outside_clock_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] n = 8'h00;
	initial outside_clock_o = 1'b0;
	// Stands low while idle, so no stray tick on select
	always @(posedge clock_i) begin
		n <= (!run_i || n + 8'h01 >= half_i) ? 8'h00 : n + 8'h01;
		if (!run_i)
			outside_clock_o <= 1'b0;
		else if (n + 8'h01 >= half_i)
			outside_clock_o <= !outside_clock_o;
	end
endmodule

// ### bench/reference_timing_generator_tb.sv
/*
 Bench of the reference timing generator: pulse spacing on internal and
 outside clock, width on internal clock, scale flags. Assumes no reset is needed mid-run.
*/
module reference_timing_generator_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import ref_timing_pkg::*;
	logic clock_i = 1'b0, arst_n_i = 1'b0, sel = 1'b0, run = 1'b0, ext_clk;
	logic con_en = 1'b0, con_ten = 1'b0, con_hun = 1'b0, sclk, ten, hun;
	scale_t panel = unity_time_scale;
	fixed_pulses_t fixed;
	scaled_pulses_t scaled;
	logic [10:0] pulses;
	int err_count = 0, checks = 0, n;
	assign pulses = {sclk, fixed, scaled};
	initial forever #5 clock_i = ~clock_i;
	far_side_model far (.clock_i(clock_i), .run_i(run), .half_i(8'h02),
		.outside_clock_o(ext_clk));
	reference_timing_generator DUT (.clock_i(clock_i), .arst_n_i(arst_n_i),
		.outside_clock_select_enable_i(sel), .outside_clock_in_i(ext_clk),
		.panel_scale_i(panel), .console_enable_i(con_en),
		.console_tenfold_i(con_ten), .console_hundredfold_i(con_hun),
		.system_clock_out_o(sclk), .fixed_pulses_o(fixed), .scaled_pulses_o(scaled),
		.tenfold_time_scale_o(ten), .hundredfold_time_scale_o(hun));
	////////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [31:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d errors %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Cycles until the next rising edge of one line, bounded
	task automatic rise(input int idx, output int k);
		logic p;
		logic hit;
		p = pulses[idx];
		hit = 1'b0;
		k = 0;
		while (!hit && k < 9000) begin
			@(negedge clock_i);
			k++;
			hit = (pulses[idx] === 1'b1 && p === 1'b0);
			p = pulses[idx];
		end
		// A limit that runs out counts as a mismatch
		if (!hit)
			err_count++;
	endtask
	// First gap is discarded: scale or clock changes may shorten it
	task automatic period(input string what, input int idx, input int exp);
		rise(idx, n);
		rise(idx, n);
		check(what, n, exp);
	endtask
	// High time after a rise, capped at 300
	task automatic width(input string what, input int idx, input int exp);
		rise(idx, n);
		n = 0;
		while (pulses[idx] === 1'b1 && n < 300) begin
			@(negedge clock_i);
			n++;
		end
		check(what, n, exp);
	endtask
	task automatic flags(input logic [2:0] con, input logic [1:0] exp);
		{con_en, con_ten, con_hun} <= con;
		repeat (3) @(posedge clock_i);
		check("flags", {ten, hun}, exp);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		#600000;
		err_count++;
		wrap_up();
	end
	initial begin
		repeat (3) @(posedge clock_i);
		check("reset", pulses, 11'h000);
		arst_n_i <= 1'b1;
		period("sysclk", 10, 100);
		width("sysclk_high", 10, 50);
		period("p10us", 4, 1000);
		width("p10us_high", 4, 100);
		@(posedge clock_i);
		for (int s = 0; s < 4; s++) begin
			panel <= scale_t'(s);
			flags(3'b000, {s == 1, s == 2});
		end
		flags(3'b101, 2'b01);
		flags(3'b110, 2'b10);
		flags(3'b111, 2'b01);
		flags(3'b011, 2'b00);
		panel <= unity_time_scale;
		sel <= 1'b1;
		run <= 1'b1;
		period("osclk", 10, 4);
		period("o10us", 4, 40);
		period("o100us", 5, 400);
		period("o1ms", 6, 4000);
		for (int s = 0; s < 3; s++) begin
			@(posedge clock_i);
			panel <= scale_t'(s);
			period("v1ms", 0, 4 * 10 ** (3 - s));
		end
		period("v10ms", 1, 400);
		@(posedge clock_i);
		panel <= thousandfold_time_scale;
		// Pulse every tick: line never drops, so count high samples
		repeat (8) @(posedge clock_i);
		n = 0;
		repeat (300) begin
			@(negedge clock_i);
			if (pulses[0] === 1'b1)
				n++;
		end
		check("v1ms_thousandfold_time_scale", n, 300);
		period("v100ms_thousandfold_time_scale", 2, 400);
		period("v1s_thousandfold_time_scale", 3, 4000);
		wrap_up();
	end
endmodule

// ### hdl/ref_timing_params.svh
/*
 Constants of the reference timing generator: clock rates, decade layout
 and pulse timing. Assumes a 100 MHz core clock and plain-count use.
*/
`ifndef REF_TIMING_PARAMS_SVH
`define REF_TIMING_PARAMS_SVH

// Core clock and logic system clock, in ns
`define RTG_CORE_PERIOD_NS 10
`define RTG_SYS_PERIOD_NS 1000
// Core cycles per system tick, and the last prescale count
`define RTG_TICK_CYCLES (`RTG_SYS_PERIOD_NS / `RTG_CORE_PERIOD_NS)
`define RTG_TICK_LAST 7'((`RTG_TICK_CYCLES) - 1)
`define RTG_TICK_HALF 7'((`RTG_TICK_CYCLES) / 2)
`define RTG_PRESCALE_W 7
// Six decades: 10 us up to 1 s
`define RTG_DECADES 6
`define RTG_DIGIT_LAST 4'h9
`define RTG_DIGIT_ZERO 4'h0
`define RTG_DIGIT_ONE 4'h1

`endif

// ### hdl/ref_timing_pkg.sv
/*
 Types of the reference timing generator: time scales, pulse groups and
 the registered state. Assumes ref_timing_params.svh is on the include path.
*/
`include "ref_timing_params.svh"

package ref_timing_pkg;

	typedef enum logic [1:0] {
		unity_time_scale,
		tenfold_time_scale,
		hundredfold_time_scale,
		thousandfold_time_scale
	} scale_t;

	typedef struct packed {
		logic fixed_pulse_1s;
		logic fixed_pulse_100ms;
		logic fixed_pulse_10ms;
		logic fixed_pulse_1ms;
		logic fixed_pulse_100us;
		logic fixed_pulse_10us;
	} fixed_pulses_t;

	typedef struct packed {
		logic scaled_pulse_1s;
		logic scaled_pulse_100ms;
		logic scaled_pulse_10ms;
		logic scaled_pulse_1ms;
	} scaled_pulses_t;

	typedef struct packed {
		logic [`RTG_PRESCALE_W-1:0] prescale;
		logic outside_prev;
		scale_t scale;
		logic [`RTG_DECADES-1:0][3:0] fixed_digit;
		logic [`RTG_DECADES-1:0][3:0] scaled_digit;
		fixed_pulses_t fixed;
		scaled_pulses_t scaled;
		logic system_clock;
		logic tenfold;
		logic hundredfold;
	} state_t;

endpackage

// ### hdl/reference_timing_generator.sv
/*
 Reference timing generator: selects the logic system clock and derives
 fixed-rate and time-scaled one-tick pulses from decade counters.
 Assumes all inputs are synchronous to clock_i (100 MHz); the outside
 clock is sampled, so it must run well below half the core rate.
*/
// Summary of operation
// - Clock is internal 1 MHz or outside source
// - Select enable picks outside clock; clock output
// - Every pulse lasts one system clock period
// - Fixed pulses every 10 us to 1 s
// - Unity scale: scaled pulses 1 ms to 1 s
// - Higher scales speed scaled pulses by decades
// - Scale flags out; console scale when enabled

module reference_timing_generator
	import ref_timing_pkg::*;
(
	input wire logic clock_i,
	input wire logic arst_n_i,
	input wire logic outside_clock_select_enable_i,
	input wire logic outside_clock_in_i,
	input wire ref_timing_pkg::scale_t panel_scale_i,
	input wire logic console_enable_i,
	input wire logic console_tenfold_i,
	input wire logic console_hundredfold_i,
	output logic system_clock_out_o,
	output ref_timing_pkg::fixed_pulses_t fixed_pulses_o,
	output ref_timing_pkg::scaled_pulses_t scaled_pulses_o,
	output logic tenfold_time_scale_o,
	output logic hundredfold_time_scale_o
);
	import ref_timing_pkg::*;

	////////////////////////////////////////////////////////////////////
	state_t st;
	state_t next_st;
	logic tick;
	logic [`RTG_DECADES:0] fixed_carry;
	logic [`RTG_DECADES:0] scaled_carry;

	// One system clock period per tick, from crystal count or outside edge
	assign tick = outside_clock_select_enable_i ?
		(outside_clock_in_i && !st.outside_prev) :
		(st.prescale == `RTG_TICK_LAST);

	////////////////////////////////////////////////////////////////////
	always_comb begin
		next_st = st;
		fixed_carry = '0;
		scaled_carry = '0;
		// Crystal prescaler runs free so a switch back resumes at once
		if (st.prescale == `RTG_TICK_LAST) begin
			next_st.prescale = '0;
		end else begin
			next_st.prescale = st.prescale + 7'h01;
		end
		next_st.outside_prev = outside_clock_in_i;
		if (outside_clock_select_enable_i) begin
			next_st.system_clock = outside_clock_in_i;
		end else begin
			next_st.system_clock = (st.prescale < `RTG_TICK_HALF);
		end
		// Console scale wins only while enabled; hundredfold over tenfold
		if (console_enable_i) begin
			if (console_hundredfold_i) begin
				next_st.scale = hundredfold_time_scale;
			end else if (console_tenfold_i) begin
				next_st.scale = tenfold_time_scale;
			end else begin
				next_st.scale = unity_time_scale;
			end
		end else begin
			next_st.scale = panel_scale_i;
		end
		next_st.tenfold = (st.scale == tenfold_time_scale);
		next_st.hundredfold = (st.scale == hundredfold_time_scale);
		// Fixed chain: every digit counts from the tick upward
		fixed_carry[0] = tick;
		for (int i = 0; i < `RTG_DECADES; i++) begin
			if (fixed_carry[i]) begin
				next_st.fixed_digit[i] = (st.fixed_digit[i] == `RTG_DIGIT_LAST) ?
					`RTG_DIGIT_ZERO : st.fixed_digit[i] + `RTG_DIGIT_ONE;
			end
			fixed_carry[i+1] = fixed_carry[i] && (st.fixed_digit[i] == `RTG_DIGIT_LAST);
		end
		// Scaled chain: the tick enters at the decade the scale picks,
		// skipped lower digits stay frozen
		for (int i = 0; i < `RTG_DECADES; i++) begin
			if (i == int'(st.scale)) begin
				scaled_carry[i] = tick;
			end
			if (scaled_carry[i]) begin
				next_st.scaled_digit[i] = (st.scaled_digit[i] == `RTG_DIGIT_LAST) ?
					`RTG_DIGIT_ZERO : st.scaled_digit[i] + `RTG_DIGIT_ONE;
			end
			scaled_carry[i+1] = scaled_carry[i] && (st.scaled_digit[i] == `RTG_DIGIT_LAST);
		end
		// Outputs change only on ticks, so each strobe spans one period
		if (tick) begin
			next_st.fixed.fixed_pulse_10us = fixed_carry[1];
			next_st.fixed.fixed_pulse_100us = fixed_carry[2];
			next_st.fixed.fixed_pulse_1ms = fixed_carry[3];
			next_st.fixed.fixed_pulse_10ms = fixed_carry[4];
			next_st.fixed.fixed_pulse_100ms = fixed_carry[5];
			next_st.fixed.fixed_pulse_1s = fixed_carry[6];
			next_st.scaled.scaled_pulse_1ms = scaled_carry[3];
			next_st.scaled.scaled_pulse_10ms = scaled_carry[4];
			next_st.scaled.scaled_pulse_100ms = scaled_carry[5];
			next_st.scaled.scaled_pulse_1s = scaled_carry[6];
		end
	end

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign system_clock_out_o = st.system_clock;
	assign fixed_pulses_o = st.fixed;
	assign scaled_pulses_o = st.scaled;
	assign tenfold_time_scale_o = st.tenfold;
	assign hundredfold_time_scale_o = st.hundredfold;

	////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!arst_n_i);

	sequence outside_rise_s;
		outside_clock_select_enable_i && outside_clock_in_i && !st.outside_prev;
	endsequence

	sequence unity_held_s;
		(!console_enable_i && panel_scale_i == unity_time_scale)[*2];
	endsequence

	sequence crystal_tick_s;
		!outside_clock_select_enable_i && st.prescale == `RTG_TICK_LAST;
	endsequence

	outside_clock_a: assert property (
		outside_clock_select_enable_i |=> system_clock_out_o == $past(outside_clock_in_i))
		else $error("clock output does not follow outside clock");

	outside_tick_a: assert property (
		outside_rise_s ##0 (st.fixed_digit[0] == `RTG_DIGIT_LAST)
		|=> fixed_pulses_o.fixed_pulse_10us)
		else $error("outside clock edge did not drive the fixed chain");

	pulse_hold_a: assert property (
		!tick |=> $stable(fixed_pulses_o) && $stable(scaled_pulses_o))
		else $error("pulse output changed between ticks");

	pulse_width_a: assert property (
		(!outside_clock_select_enable_i)[*8] ##0 $rose(fixed_pulses_o.fixed_pulse_10us)
		|-> fixed_pulses_o.fixed_pulse_10us[*8])
		else $error("pulse shorter than one system period");

	fixed_nest_a: assert property (
		fixed_pulses_o.fixed_pulse_100us |-> fixed_pulses_o.fixed_pulse_10us)
		else $error("fixed 100 us pulse without 10 us pulse");

	scaled_unity_a: assert property (
		tick && st.scale == unity_time_scale && st.scaled_digit[0] == `RTG_DIGIT_LAST
		&& st.scaled_digit[1] == `RTG_DIGIT_LAST && st.scaled_digit[2] == `RTG_DIGIT_LAST
		|=> scaled_pulses_o.scaled_pulse_1ms)
		else $error("unity scale 1 ms pulse missing");

	scaled_thousand_a: assert property (
		tick && st.scale == thousandfold_time_scale |=> scaled_pulses_o.scaled_pulse_1ms)
		else $error("thousandfold scale did not pulse every tick");

	console_gate_a: assert property (
		unity_held_s |=> !tenfold_time_scale_o && !hundredfold_time_scale_o)
		else $error("scale flag set while console disabled at unity");

	console_pick_a: assert property (
		(console_enable_i && console_hundredfold_i)[*2]
		|=> hundredfold_time_scale_o && !tenfold_time_scale_o)
		else $error("enabled console hundredfold not reported");

	wrap_zero_a: assert property (
		$rose(fixed_pulses_o.fixed_pulse_1ms) |-> st.fixed_digit[0] == `RTG_DIGIT_ZERO
		&& st.fixed_digit[1] == `RTG_DIGIT_ZERO && st.fixed_digit[2] == `RTG_DIGIT_ZERO)
		else $error("1 ms strobe not at decade wrap");

	crystal_tick_a: assert property (
		crystal_tick_s ##0 (st.fixed_digit[0] == `RTG_DIGIT_LAST)
		|=> fixed_pulses_o.fixed_pulse_10us)
		else $error("crystal tick did not drive the fixed chain");

	crystal_half_a: assert property (
		!outside_clock_select_enable_i && st.prescale == `RTG_TICK_HALF
		|=> !system_clock_out_o)
		else $error("system clock not low in second half period");

	fixed_order_a: assert property (
		(!fixed_pulses_o.fixed_pulse_1ms || fixed_pulses_o.fixed_pulse_100us)
		&& (!fixed_pulses_o.fixed_pulse_10ms || fixed_pulses_o.fixed_pulse_1ms)
		&& (!fixed_pulses_o.fixed_pulse_100ms || fixed_pulses_o.fixed_pulse_10ms)
		&& (!fixed_pulses_o.fixed_pulse_1s || fixed_pulses_o.fixed_pulse_100ms))
		else $error("slower fixed pulse without the faster ones");

	scaled_order_a: assert property (
		(!scaled_pulses_o.scaled_pulse_10ms || scaled_pulses_o.scaled_pulse_1ms)
		&& (!scaled_pulses_o.scaled_pulse_100ms || scaled_pulses_o.scaled_pulse_10ms)
		&& (!scaled_pulses_o.scaled_pulse_1s || scaled_pulses_o.scaled_pulse_100ms))
		else $error("slower scaled pulse without the faster ones");

	// Skipped low digits must hold, or a later scale drop starts mid-count
	scaled_freeze_a: assert property (
		st.scale == thousandfold_time_scale |=> $stable(st.scaled_digit[2:0]))
		else $error("digits below the thousandfold entry moved");

	console_ten_a: assert property (
		(console_enable_i && console_tenfold_i && !console_hundredfold_i)[*2]
		|=> tenfold_time_scale_o && !hundredfold_time_scale_o)
		else $error("enabled console tenfold not reported");

endmodule
